/* design/gpabc_port_ctrl.sv */
// pin control for port a (pad options), port b and port c
// What this block does
// RULE1: port b registers decode at base 0x400C_0100.
// RULE2: port c registers decode at base 0x400C_0200, same offsets.
// RULE3: port b registers sit at fixed offsets from their base.
// RULE4: port c has two function registers; other gaps are reserved.
// RULE5: software never touches reserved offsets.
// RULE6: drain bit 0 push-pull, 1 open-drain.
// RULE7: pull-up bit 1 enables the pin pull-up.
// RULE8: pull-down bit 1 enables the pin pull-down.
// RULE9: input bit 1 enables the input path, 0 disables it.
// RULE10: output bit 1 enables the pin driver.
// RULE11: function bit 0 gives port use, 1 the assigned peripheral.
// RULE12: port a pull-up resets with bits 4, 3 and 1 set.
// RULE13: port a pull-down resets with only bit 2 set.
// RULE14: port a input enable resets with bits 4 to 1 set.
// RULE15: port b has pins 0 to 6; upper bits read zero.
// RULE16: port b input enable holds bits 5 to 0 only.
// RULE17: port b function 1 maps bus, strobe, select and trace signals.
// RULE18: port b function 2 maps clock out and serial 2; bits 1,0 zero.
// RULE19: port b function 3 maps motor timer, emergency and uart 3.
// RULE20: port b function 4 maps timer 3, interrupts, capture; bits 1,0 zero.
// RULE21: port c data holds eight read-write bits, reset zero.
// RULE22: port c output enables all reset to disabled.
// RULE23: software sets at most one function bit per pin.
// RULE24: input paths come out of reset disabled unless reset says otherwise.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module gpabc_port_ctrl
(
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	// wishbone slave
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [31:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	// pin levels seen at the pads
	input wire logic [7:0] I_PB_PIN,
	input wire logic [7:0] I_PC_PIN,
	// peripheral output values, one word per function register
	input wire logic [3:0][7:0] I_PB_ALT,
	input wire logic [1:0][7:0] I_PC_ALT,
	// pad controls
	output gpabc_pkg::gpabc_pad_s O_PA_PAD,
	output gpabc_pkg::gpabc_pad_s O_PB_PAD,
	output gpabc_pkg::gpabc_pad_s O_PC_PAD,
	// pin levels handed to the peripherals
	output logic [7:0] O_PB_ALT_IN,
	output logic [7:0] O_PC_ALT_IN
);

	////////////////////////////////////////////////////////////////////////
	// bus decode

	logic [7:0] reg_ff [0:2][0:15];
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic [7:0] pb_pin_ff;
	logic [7:0] pc_pin_ff;
	logic req;
	logic hit;
	logic wr_hit;
	logic [1:0] sel_port;
	logic [3:0] sel_idx;
	logic [7:0] sel_mask;
	logic [7:0] rd_byte;

	assign req = I_WB_CYC && I_WB_STB && !ack_ff;
	assign sel_port = I_WB_ADR[9:8];
	assign sel_idx = I_WB_ADR[5:2];
	assign sel_mask = gpabc_pkg::reg_mask(sel_port, sel_idx);

	// block, port and word decode; reserved words have a zero mask
	assign hit = (I_WB_ADR[31:12] == gpabc_pkg::BASE_HI) && // RULE1 RULE2
		(I_WB_ADR[11:10] == 2'b00) && (sel_port != 2'b11) &&
		(I_WB_ADR[7:6] == 2'b00) && (I_WB_ADR[1:0] == 2'b00) &&
		(sel_mask != 8'h00); // RULE3 RULE4
	assign wr_hit = req && I_WB_WE && I_WB_SEL[0] && hit;

	////////////////////////////////////////////////////////////////////////
	// register file

	// writes keep only implemented bits, so the rest always read zero
	always_ff @(posedge I_CORE_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			for (int p = 0; p < 3; p++)
				for (int i = 0; i < 16; i++)
					reg_ff[p][i] <= gpabc_pkg::reg_reset(2'(p),
						4'(i)); // RULE12 RULE13 RULE14 RULE21 RULE22 RULE24
		end
		else if (wr_hit)
			reg_ff[sel_port][sel_idx] <= I_WB_DAT[7:0] & sel_mask; // RULE15 RULE16 RULE18 RULE20
	end

	// pins sampled once; inputs are synchronous to the core clock
	always_ff @(posedge I_CORE_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			pb_pin_ff <= 8'h00;
			pc_pin_ff <= 8'h00;
		end
		else
		begin
			pb_pin_ff <= I_PB_PIN;
			pc_pin_ff <= I_PC_PIN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path and acknowledge

	// data word shows the pin for enabled inputs, the latch otherwise
	always_comb
	begin
		rd_byte = reg_ff[sel_port == 2'b11 ? 2'b00 : sel_port][sel_idx];
		if (sel_idx == gpabc_pkg::IDX_DATA && sel_port == 2'b01)
			rd_byte = (rd_byte & ~reg_ff[1][gpabc_pkg::IDX_INEN]) |
				(pb_pin_ff & reg_ff[1][gpabc_pkg::IDX_INEN]); // RULE9
		if (sel_idx == gpabc_pkg::IDX_DATA && sel_port == 2'b10)
			rd_byte = (rd_byte & ~reg_ff[2][gpabc_pkg::IDX_INEN]) |
				(pc_pin_ff & reg_ff[2][gpabc_pkg::IDX_INEN]); // RULE9
		rd_byte = rd_byte & sel_mask;
	end

	// one wait state; unmapped words still answer, reading zero
	always_ff @(posedge I_CORE_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= req;
			if (req && !I_WB_WE && hit)
				rdat_ff <= {24'h00_0000, rd_byte};
			else
				rdat_ff <= 32'h0000_0000; // RULE5
		end
	end

	assign O_WB_ACK = ack_ff;
	assign O_WB_DAT = rdat_ff;

	////////////////////////////////////////////////////////////////////////
	// pad logic

	logic [7:0] pb_fsel_any;
	logic [7:0] pc_fsel_any;
	logic [7:0] pb_alt_val;
	logic [7:0] pc_alt_val;
	gpabc_pkg::gpabc_pad_s nxt_pb_pad;
	gpabc_pkg::gpabc_pad_s nxt_pc_pad;
	gpabc_pkg::gpabc_pad_s nxt_pa_pad;
	gpabc_pkg::gpabc_pad_s pa_pad_ff;
	gpabc_pkg::gpabc_pad_s pb_pad_ff;
	gpabc_pkg::gpabc_pad_s pc_pad_ff;
	logic [7:0] pb_alt_in_ff;
	logic [7:0] pc_alt_in_ff;

	// peripheral routing; with one bit per pin the or is a plain mux
	always_comb
	begin
		pb_fsel_any = 8'h00;
		pb_alt_val = 8'h00;
		for (int k = 0; k < 4; k++)
		begin
			pb_fsel_any = pb_fsel_any |
				reg_ff[1][gpabc_pkg::IDX_FSEL1 + 4'(k)];
			pb_alt_val = pb_alt_val | (I_PB_ALT[k] & // RULE17 RULE19 RULE20
				reg_ff[1][gpabc_pkg::IDX_FSEL1 + 4'(k)]); // RULE11
		end
		pc_fsel_any = reg_ff[2][gpabc_pkg::IDX_FSEL1] |
			reg_ff[2][gpabc_pkg::IDX_FSEL2];
		pc_alt_val = (I_PC_ALT[0] & reg_ff[2][gpabc_pkg::IDX_FSEL1]) |
			(I_PC_ALT[1] & reg_ff[2][gpabc_pkg::IDX_FSEL2]); // RULE11
	end

	function automatic gpabc_pkg::gpabc_pad_s pad_of(logic [1:0] p,
		logic [7:0] fsel, logic [7:0] alt);
		gpabc_pkg::gpabc_pad_s d;
		d.level = (fsel & alt) | (~fsel & reg_ff[p][gpabc_pkg::IDX_DATA]);
		d.open_drain = reg_ff[p][gpabc_pkg::IDX_ODRAIN];
		// open-drain releases the pad instead of driving it high
		d.drive_n = ~(reg_ff[p][gpabc_pkg::IDX_OUTEN] &
			~(d.open_drain & d.level)); // RULE6 RULE10
		d.pull_up = reg_ff[p][gpabc_pkg::IDX_PULLUP]; // RULE7
		d.pull_dn = reg_ff[p][gpabc_pkg::IDX_PULLDN]; // RULE8
		d.in_en = reg_ff[p][gpabc_pkg::IDX_INEN]; // RULE9
		return d;
	endfunction

	// port a only carries its pad options here; its driver stays off
	always_comb
	begin
		nxt_pb_pad = pad_of(2'b01, pb_fsel_any, pb_alt_val);
		nxt_pc_pad = pad_of(2'b10, pc_fsel_any, pc_alt_val);
		nxt_pa_pad = pad_of(2'b00, 8'h00, 8'h00);
		nxt_pa_pad.level = 8'h00;
		nxt_pa_pad.drive_n = 8'hFF;
	end

	// registered pads so every output comes from a flip-flop
	always_ff @(posedge I_CORE_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			pa_pad_ff <= '{8'h00, 8'hFF, 8'h00, gpabc_pkg::RST_PA_PULLUP,
				gpabc_pkg::RST_PA_PULLDN, gpabc_pkg::RST_PA_INEN};
			pb_pad_ff <= '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
			pc_pad_ff <= '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00}; // RULE22
		end
		else
		begin
			pa_pad_ff <= nxt_pa_pad;
			pb_pad_ff <= nxt_pb_pad;
			pc_pad_ff <= nxt_pc_pad;
		end
	end

	// disabled input paths hand the peripherals a steady zero
	always_ff @(posedge I_CORE_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			pb_alt_in_ff <= 8'h00;
			pc_alt_in_ff <= 8'h00;
		end
		else
		begin
			pb_alt_in_ff <= pb_pin_ff & reg_ff[1][gpabc_pkg::IDX_INEN] &
				pb_fsel_any; // RULE9 RULE11
			pc_alt_in_ff <= pc_pin_ff & reg_ff[2][gpabc_pkg::IDX_INEN] &
				pc_fsel_any; // RULE9 RULE11
		end
	end

	assign O_PA_PAD = pa_pad_ff;
	assign O_PB_PAD = pb_pad_ff;
	assign O_PC_PAD = pc_pad_ff;
	assign O_PB_ALT_IN = pb_alt_in_ff;
	assign O_PC_ALT_IN = pc_alt_in_ff;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_RST);

	sequence s_bus_req;
		I_WB_CYC && I_WB_STB && !O_WB_ACK;
	endsequence

	sequence s_bus_ack;
		O_WB_ACK ##1 !O_WB_ACK;
	endsequence

	// one read or write of a given word, taken at this edge
	sequence s_rd_at(logic [31:0] a);
		s_bus_req ##0 (!I_WB_WE && I_WB_ADR == a);
	endsequence

	sequence s_wr_at(logic [31:0] a);
		s_bus_req ##0 (I_WB_WE && I_WB_SEL[0] && I_WB_ADR == a);
	endsequence

	a_ack_one_wait: // RULE3
		assert property (s_bus_req |=> s_bus_ack)
		else $error("ack not given one cycle after request");

	a_pb_data_upper: // RULE1 RULE15
		assert property (s_rd_at(32'h400C_0100) |=>
			O_WB_DAT[31:7] == 25'h0)
		else $error("port b data upper bits not zero");

	a_pb_ie_bit6: // RULE16
		assert property (s_rd_at(32'h400C_0138) |=>
			O_WB_DAT[31:6] == 26'h0)
		else $error("port b input enable bit 6 or above set");

	a_pc_fs2_upper: // RULE2 RULE4
		assert property (s_rd_at(32'h400C_020C) |=>
			O_WB_DAT[31:2] == 30'h0)
		else $error("port c function 2 upper bits set");

	a_pb_fs2_low: // RULE18
		assert property (s_rd_at(32'h400C_010C) |=>
			O_WB_DAT[1:0] == 2'b00)
		else $error("port b function 2 low bits set");

	a_pb_fs3_upper: // RULE19
		assert property (s_rd_at(32'h400C_0110) |=>
			O_WB_DAT[31:6] == 26'h0)
		else $error("port b function 3 bit 6 or above set");

	a_pb_fs4_low: // RULE20
		assert property (s_rd_at(32'h400C_0114) |=>
			O_WB_DAT[1:0] == 2'b00 && O_WB_DAT[31:7] == 25'h0)
		else $error("port b function 4 unused bits set");

	a_pc_data_write: // RULE21
		assert property (s_wr_at(32'h400C_0200) |=>
			reg_ff[2][gpabc_pkg::IDX_DATA] == $past(I_WB_DAT[7:0]))
		else $error("port c data write not held");

	a_outen_off: // RULE10
		assert property ((reg_ff[2][gpabc_pkg::IDX_OUTEN][0] == 1'b0)[*2]
			|-> O_PC_PAD.drive_n[0])
		else $error("port c pin 0 driven while output disabled");

	a_od_release: // RULE6
		assert property (($stable(nxt_pb_pad) &&
			reg_ff[1][gpabc_pkg::IDX_ODRAIN][0] && O_PB_PAD.level[0]) |->
			O_PB_PAD.drive_n[0])
		else $error("open-drain pin driven high");

	a_ie_gate: // RULE9 RULE24
		assert property ((reg_ff[1][gpabc_pkg::IDX_INEN][0] == 1'b0)[*2]
			|-> O_PB_ALT_IN[0] == 1'b0)
		else $error("disabled input reached peripheral");

	a_pc_ie_gate: // RULE9
		assert property ((reg_ff[2][gpabc_pkg::IDX_INEN][0] == 1'b0)[*2]
			|-> O_PC_ALT_IN[0] == 1'b0)
		else $error("disabled port c input reached peripheral");

	a_pull_follow: // RULE7 RULE8
		assert property (1'b1 |=> O_PB_PAD.pull_up ==
			$past(reg_ff[1][gpabc_pkg::IDX_PULLUP]) && O_PB_PAD.pull_dn ==
			$past(reg_ff[1][gpabc_pkg::IDX_PULLDN]))
		else $error("pull controls do not follow registers");

	a_fsel_route: // RULE11
		assert property ((reg_ff[1][gpabc_pkg::IDX_FSEL3][0] &&
			!reg_ff[1][gpabc_pkg::IDX_FSEL1][0]) |=>
			O_PB_PAD.level[0] == $past(I_PB_ALT[2][0]))
		else $error("function pin not routed to peripheral");

	a_pa_reset: // RULE12 RULE13 RULE14
		assert property ($past(I_RST) |-> O_PA_PAD.pull_up == 8'h1A &&
			O_PA_PAD.pull_dn == 8'h04 && O_PA_PAD.in_en == 8'h1E)
		else $error("port a pad reset values wrong");

	a_pc_reset: // RULE22 RULE24
		assert property ($past(I_RST) |-> O_PC_PAD.drive_n == 8'hFF &&
			O_PC_PAD.in_en == 8'h00 && O_PB_PAD.in_en == 8'h00)
		else $error("port b or c pad not idle after reset");

endmodule

/* design/gpabc_pkg.sv */
// constants, field masks and pad carrier for the port a/b/c pin control
package gpabc_pkg;

	// address map: bits 31..12 select the block, 11..8 the port
	localparam logic [19:0] BASE_HI = 20'h400C0;
	localparam logic [3:0] PORTA_SEL = 4'h0;
	localparam logic [3:0] PORTB_SEL = 4'h1;
	localparam logic [3:0] PORTC_SEL = 4'h2;

	// byte offsets inside one port group
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_OUTEN = 8'h04;
	localparam logic [7:0] OFS_FSEL1 = 8'h08;
	localparam logic [7:0] OFS_FSEL2 = 8'h0C;
	localparam logic [7:0] OFS_FSEL3 = 8'h10;
	localparam logic [7:0] OFS_FSEL4 = 8'h14;
	localparam logic [7:0] OFS_ODRAIN = 8'h28;
	localparam logic [7:0] OFS_PULLUP = 8'h2C;
	localparam logic [7:0] OFS_PULLDN = 8'h30;
	localparam logic [7:0] OFS_INEN = 8'h38;

	// word index of each register
	localparam logic [3:0] IDX_DATA = OFS_DATA[5:2];
	localparam logic [3:0] IDX_OUTEN = OFS_OUTEN[5:2];
	localparam logic [3:0] IDX_FSEL1 = OFS_FSEL1[5:2];
	localparam logic [3:0] IDX_FSEL2 = OFS_FSEL2[5:2];
	localparam logic [3:0] IDX_FSEL3 = OFS_FSEL3[5:2];
	localparam logic [3:0] IDX_FSEL4 = OFS_FSEL4[5:2];
	localparam logic [3:0] IDX_ODRAIN = OFS_ODRAIN[5:2];
	localparam logic [3:0] IDX_PULLUP = OFS_PULLUP[5:2];
	localparam logic [3:0] IDX_PULLDN = OFS_PULLDN[5:2];
	localparam logic [3:0] IDX_INEN = OFS_INEN[5:2];

	// implemented bits per register
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [7:0] MASK_PB_PIN = 8'h7F;
	localparam logic [7:0] MASK_PB_IE = 8'h3F;
	localparam logic [7:0] MASK_PB_FS2 = 8'h7C;
	localparam logic [7:0] MASK_PB_FS3 = 8'h3F;
	localparam logic [7:0] MASK_PB_FS4 = 8'h7C;
	localparam logic [7:0] MASK_PC_FS2 = 8'h03;

	// values after reset
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_PA_PULLUP = 8'h1A;
	localparam logic [7:0] RST_PA_PULLDN = 8'h04;
	localparam logic [7:0] RST_PA_INEN = 8'h1E;

	// one pad's controls, eight pins wide
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] drive_n;
		logic [7:0] open_drain;
		logic [7:0] pull_up;
		logic [7:0] pull_dn;
		logic [7:0] in_en;
	} gpabc_pad_s;

	// zero mask marks an unmapped or reserved word
	function automatic logic [7:0] reg_mask(logic [1:0] p, logic [3:0] i);
		logic [7:0] m;
		m = 8'h00;
		if (p == PORTA_SEL[1:0])
		begin
			if (i == IDX_ODRAIN || i == IDX_PULLUP || i == IDX_PULLDN ||
				i == IDX_INEN)
				m = MASK_FULL;
		end
		else if (p == PORTB_SEL[1:0])
		begin
			unique case (i)
				IDX_DATA, IDX_OUTEN, IDX_FSEL1: m = MASK_PB_PIN;
				IDX_ODRAIN, IDX_PULLUP, IDX_PULLDN: m = MASK_PB_PIN;
				IDX_FSEL2: m = MASK_PB_FS2;
				IDX_FSEL3: m = MASK_PB_FS3;
				IDX_FSEL4: m = MASK_PB_FS4;
				IDX_INEN: m = MASK_PB_IE;
				default: m = 8'h00;
			endcase
		end
		else if (p == PORTC_SEL[1:0])
		begin
			unique case (i)
				IDX_DATA, IDX_OUTEN, IDX_FSEL1: m = MASK_FULL;
				IDX_ODRAIN, IDX_PULLUP, IDX_PULLDN, IDX_INEN: m = MASK_FULL;
				IDX_FSEL2: m = MASK_PC_FS2;
				default: m = 8'h00;
			endcase
		end
		return m;
	endfunction

	function automatic logic [7:0] reg_reset(logic [1:0] p, logic [3:0] i);
		logic [7:0] r;
		r = RST_ZERO;
		if (p == PORTA_SEL[1:0] && i == IDX_PULLUP)
			r = RST_PA_PULLUP;
		if (p == PORTA_SEL[1:0] && i == IDX_PULLDN)
			r = RST_PA_PULLDN;
		if (p == PORTA_SEL[1:0] && i == IDX_INEN)
			r = RST_PA_INEN;
		return r;
	endfunction

endpackage

/* verif/gpabc_pin_model.sv */
// pad and board model: resolves each pin from driver, pulls and outside level
`timescale 1ns/1ps
module gpabc_pin_model
(
	// pad controls from the block
	input gpabc_pkg::gpabc_pad_s i_pad,
	// level forced by outside circuitry when nothing else drives
	input wire logic [7:0] i_ext,
	// resolved pin level
	output logic [7:0] o_pin
);
	// driver wins, then a pull, else the board level
	always_comb
	begin
		for (int k = 0; k < 8; k++)
		begin
			if (!i_pad.drive_n[k])
				o_pin[k] = i_pad.level[k];
			else if (i_pad.pull_up[k])
				o_pin[k] = 1'b1;
			else if (i_pad.pull_dn[k])
				o_pin[k] = 1'b0;
			else
				o_pin[k] = i_ext[k];
		end
	end
endmodule

/* verif/tb_gpabc_port_ctrl.sv */
// self-checking bench for the port a/b/c pin control block
`timescale 1ns/1ps
module tb_gpabc_port_ctrl;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
	logic [31:0] adr = 0, wdat = 0, rdat;
	logic [3:0] sel = 0;
	logic ack;
	logic [7:0] ext_b = 0, ext_c = 0, pin_b, pin_c, ain_b, ain_c;
	logic [3:0][7:0] alt_b = 0;
	logic [1:0][7:0] alt_c = 0;
	gpabc_pkg::gpabc_pad_s pad_a, pad_b, pad_c;
	int n_errors = 0;
	int comparisons = 0;
	logic [7:0] ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
		8'h28, 8'h2C, 8'h30, 8'h38};
	logic [7:0] mb [10] = '{8'h7F, 8'h7F, 8'h7F, 8'h7C, 8'h3F, 8'h7C,
		8'h7F, 8'h7F, 8'h7F, 8'h3F};
	logic [7:0] mc [10] = '{8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h00, 8'h00,
		8'hFF, 8'hFF, 8'hFF, 8'hFF};

	always #25 clk = ~clk;

	gpabc_port_ctrl gpabc_port_ctrl_i (.I_CORE_CLK(clk), .I_RST(rst),
		.I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
		.I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_PB_PIN(pin_b), .I_PC_PIN(pin_c), .I_PB_ALT(alt_b),
		.I_PC_ALT(alt_c), .O_PA_PAD(pad_a), .O_PB_PAD(pad_b),
		.O_PC_PAD(pad_c), .O_PB_ALT_IN(ain_b), .O_PC_ALT_IN(ain_c));
	gpabc_pin_model gpabc_pin_model_b (.i_pad(pad_b), .i_ext(ext_b),
		.o_pin(pin_b));
	gpabc_pin_model gpabc_pin_model_c (.i_pad(pad_c), .i_ext(ext_c),
		.o_pin(pin_c));

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] addr(logic [3:0] p, logic [7:0] o);
		return {gpabc_pkg::BASE_HI, p, o};
	endfunction

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// classic cycle: hold until ack, take data there, then one idle cycle
	task automatic wb(logic w, logic [31:0] a, logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			chk("ack", 1, 0);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(logic [3:0] p, logic [7:0] o, logic [7:0] d);
		logic [31:0] r;
		wb(1'b1, addr(p, o), {24'h0, d}, r);
	endtask

	task automatic rd_chk(string nm, logic [3:0] p, logic [7:0] o,
		logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, addr(p, o), 32'h0, r);
		chk(nm, exp, r);
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset_values();
		rd_chk("pa_pullup", 4'h0, 8'h2C, 32'h1A);
		rd_chk("pa_pulldn", 4'h0, 8'h30, 32'h04);
		rd_chk("pa_inen", 4'h0, 8'h38, 32'h1E);
		chk("pa_pad_ie", 8'h1E, pad_a.in_en);
		chk("pb_pad_ie", 8'h00, pad_b.in_en);
		rd_chk("pc_data", 4'h2, 8'h00, 32'h0);
		rd_chk("pc_outen", 4'h2, 8'h04, 32'h0);
		chk("pc_drive_n", 8'hFF, pad_c.drive_n);
	endtask

	// all ones into every mapped port b word and each mapped port c word, read back the implemented bits only
	task automatic t_register_map();
		for (int i = 0; i < 10; i++)
		begin
			wr(4'h1, ofs[i], 8'hFF);
			rd_chk("pb_word", 4'h1, ofs[i], {24'h0, mb[i]});
			wr(4'h1, ofs[i], 8'h00);
			// reserved words of port c are never touched
			if (mc[i] != 8'h00)
			begin
				wr(4'h2, ofs[i], 8'hFF);
				rd_chk("pc_word", 4'h2, ofs[i], {24'h0, mc[i]});
				wr(4'h2, ofs[i], 8'h00);
			end
		end
		wr(4'h0, 8'h28, 8'hFF);
		rd_chk("pa_odrain", 4'h0, 8'h28, 32'hFF);
		wr(4'h0, 8'h30, 8'hFF);
		rd_chk("pa_pulldn_rw", 4'h0, 8'h30, 32'hFF);
		wr(4'h0, 8'h38, 8'h00);
		rd_chk("pa_inen_rw", 4'h0, 8'h38, 32'h0);
	endtask

	task automatic t_drive();
		do_reset();
		wr(4'h1, 8'h04, 8'h01);
		wr(4'h1, 8'h00, 8'h01);
		chk("pb_drive_on", 8'hFE, pad_b.drive_n);
		chk("pb_level", 8'h01, pad_b.level);
		wr(4'h1, 8'h28, 8'h01);
		chk("pb_od_bit", 8'h01, pad_b.open_drain);
		chk("pb_od_high", 8'hFF, pad_b.drive_n);
		wr(4'h1, 8'h00, 8'h00);
		chk("pb_od_low", 8'hFE, pad_b.drive_n);
		wr(4'h1, 8'h2C, 8'h41);
		chk("pb_pullup", 8'h41, pad_b.pull_up);
		wr(4'h1, 8'h30, 8'h12);
		chk("pb_pulldn", 8'h12, pad_b.pull_dn);
		wr(4'h2, 8'h04, 8'hFF);
		wr(4'h2, 8'h00, 8'hA5);
		chk("pc_level", 8'hA5, pad_c.level);
		chk("pc_drive_n", 8'h00, pad_c.drive_n);
	endtask

	task automatic t_input();
		do_reset();
		// board holds pin 0 low, so only the driven level can raise it
		ext_b <= 8'h6C;
		rd_chk("pb_in_off", 4'h1, 8'h00, 32'h0);
		wr(4'h1, 8'h38, 8'hFF);
		chk("pb_pad_ie", 8'h3F, pad_b.in_en);
		rd_chk("pb_in_on", 4'h1, 8'h00, 32'h2C);
		alt_b[0] <= 8'h01;
		wr(4'h1, 8'h04, 8'h01);
		wr(4'h1, 8'h08, 8'h01);
		chk("pb_alt_level", 8'h01, pad_b.level);
		repeat (3) @(posedge clk);
		chk("pb_alt_in", 8'h01, ain_b);
		// pin 7 is high outside but has no function selected
		ext_c <= 8'h81;
		wr(4'h2, 8'h38, 8'hFF);
		wr(4'h2, 8'h0C, 8'h01);
		repeat (3) @(posedge clk);
		chk("pc_alt_in", 8'h01, ain_c);
	endtask

	////////////////////////////////////////////////////////////////////////
	// verdict and run control
	task automatic final_report();
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset_values();
		t_register_map();
		t_drive();
		t_input();
		final_report();
	end

	// about 80 bus cycles (some 258 clocks) expected; cut off well beyond that
	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule
